// File: src/lcdpx_pkg.sv
// Shared constants and types for the LCD power-down and segment expansion block.
// Assumes a 32-bit AHB-Lite register bus and an LCD subclock on its own port.
package lcdpx_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] LCDPX_CTRL_OFS = 8'h00;
  localparam logic [7:0] LCDPX_STAT_OFS = 8'h04;
  localparam logic [7:0] LCDPX_DATA_OFS = 8'h10;
  localparam int LCDPX_NWORDS = 4;
  localparam int LCDPX_WBITS = 32;
  localparam logic [1:0] LCDPX_LAST_WORD = 2'h3;
  localparam logic [4:0] LCDPX_LAST_BIT = 5'h1f;

  // ==========================================================================
  // Control register layout (lcd_port_control_reg)
  localparam int LCDPX_ACT_BIT = 0;
  localparam int LCDPX_PSW_BIT = 1;
  localparam int LCDPX_SGX_BIT = 2;
  localparam int LCDPX_FCS_LSB = 4;
  localparam int LCDPX_SGS_LSB = 8;
  typedef struct packed {
    logic [3:0] segment_range_select;
    logic [3:0] frame_clock_select;
    logic       rsvd;
    logic       segment_expansion_select;
    logic       lcd_supply_switch;
    logic       display_active;
  } lcdpx_ctrl_t;
  localparam logic [11:0] LCDPX_CTRL_RST = 12'h000;

  // Frame clock select: bit 3 clear picks the subclock, bits 1:0 its divider
  localparam logic [1:0] LCDPX_SUB_DIV1 = 2'h0;
  localparam logic [1:0] LCDPX_SUB_DIV2 = 2'h1;
  localparam logic [1:0] LCDPX_SUB_DIV4 = 2'h2;
  localparam int LCDPX_FCS_SYS_BIT = 3;
  localparam int LCDPX_SYSDIV_W = 9;

  // Status register bit positions
  localparam int LCDPX_ST_RUN = 0;
  localparam int LCDPX_ST_SUPPLY = 1;
  localparam int LCDPX_ST_SUBCLK = 2;
  localparam int LCDPX_ST_PINS = 3;

  // ==========================================================================
  // Operating modes reported by the power controller
  typedef enum logic [2:0] {
    LCDPX_PM_ACTIVE, LCDPX_PM_SLEEP, LCDPX_PM_WATCH, LCDPX_PM_SUBACTIVE,
    LCDPX_PM_SUBSLEEP, LCDPX_PM_STANDBY, LCDPX_PM_MODSTBY
  } lcdpx_pmode_t;

  // Expansion pin group driven toward the external segment driver
  typedef struct packed {
    logic data_out;
    logic expansion_latch_clock;
    logic expansion_shift_clock;
    logic polarity;
  } lcdpx_exp_t;

endpackage

// File: src/lcdpx_link.sv
// Expansion serialiser running on the LCD subclock domain.
// Assumes levels from the system domain are quasi-static; words arrive by handshake.
`timescale 1ns/1ps
`default_nettype none
module lcdpx_link
  import lcdpx_pkg::*;
(
  // Link clock and reset
  input wire logic lcd_clk,
  input wire logic rst_b,
  // Levels and events from the system domain
  input wire logic run_lvl,
  input wire logic use_sys,
  input wire logic [1:0] sub_div,
  input wire logic sys_tick_lvl,
  // Word fetch handshake
  output logic req_tgl,
  output logic [1:0] req_idx,
  input wire logic ack_tgl,
  input wire logic [31:0] word,
  // Expansion pins
  output lcdpx_exp_t exp_pins
);

  typedef enum logic [2:0] {L_IDLE, L_WAIT, L_LOW, L_HIGH, L_LATCH} lcdpx_lst_t;

  // ==========================================================================
  // Reset release and synchronisers
  logic [1:0] rst_sync_q;
  logic lrst_b;
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic tick_prev_q;
  logic ack_prev_q;
  // Release is synchronised so no flop leaves reset on a partial edge
  always_ff @(posedge lcd_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign lrst_b = rst_sync_q[1];

  // Two flops for every level; first stage feeds only the second
  always_ff @(posedge lcd_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      tick_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      s1_q <= {ack_tgl, sys_tick_lvl, use_sys, run_lvl, 1'b0};
      s2_q <= s1_q;
      tick_prev_q <= s2_q[3];
      ack_prev_q <= s2_q[4];
    end
  end

  // ==========================================================================
  // Frame tick: subclock divided, or system-clock event
  logic [1:0] sdiv1_q;
  logic [1:0] sdiv2_q;
  logic [1:0] cnt_q;
  wire run_s = s2_q[1];
  wire sys_s = s2_q[2];
  wire sys_edge = s2_q[3] ^ tick_prev_q;
  wire ack_edge = s2_q[4] ^ ack_prev_q;
  wire pend = req_tgl ^ s2_q[4];
  wire sub_tick = (sdiv2_q == LCDPX_SUB_DIV1) ||
                  (sdiv2_q == LCDPX_SUB_DIV2 && cnt_q[0]) ||
                  (sdiv2_q == LCDPX_SUB_DIV4 && cnt_q == 2'h3);
  wire tick = sys_s ? sys_edge : sub_tick; // RL11
  always_ff @(posedge lcd_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      sdiv1_q <= 2'h0;
      sdiv2_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      sdiv1_q <= sub_div;
      sdiv2_q <= sdiv1_q;
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // ==========================================================================
  // Serial sequencer
  lcdpx_lst_t st_q;
  logic [4:0] bit_q;
  logic [1:0] widx_q;
  logic have_q;
  logic [31:0] nxt_q;
  logic [31:0] cur_q;
  // Halt forces clocks and polarity low but leaves data_out untouched
  always_ff @(posedge lcd_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      st_q <= L_IDLE;
      bit_q <= 5'h00;
      widx_q <= 2'h0;
      have_q <= 1'b0;
      nxt_q <= 32'h0;
      cur_q <= 32'h0;
      req_tgl <= 1'b0;
      req_idx <= 2'h0;
      exp_pins <= '0;
    end else begin
      if (ack_edge) begin
        nxt_q <= word;
        have_q <= 1'b1;
      end
      if (!run_s) begin
        st_q <= L_IDLE; // RL9
        exp_pins.expansion_shift_clock <= 1'b0; // RL9
        exp_pins.expansion_latch_clock <= 1'b0; // RL9
        exp_pins.polarity <= 1'b0; // RL9
      end else begin
        unique case (st_q)
          L_IDLE: begin
            // Start only once no stale fetch is in flight
            if (!pend) begin
              req_idx <= 2'h0; // RL8
              req_tgl <= ~req_tgl;
              have_q <= 1'b0;
              st_q <= L_WAIT;
            end
          end
          L_WAIT: begin
            if (have_q && !ack_edge) begin
              cur_q <= nxt_q;
              widx_q <= req_idx;
              have_q <= 1'b0;
              req_idx <= req_idx + 2'h1;
              req_tgl <= ~req_tgl;
              bit_q <= 5'h00;
              st_q <= L_LOW;
            end
          end
          L_LOW: begin
            if (tick) begin
              exp_pins.expansion_shift_clock <= 1'b0;
              exp_pins.expansion_latch_clock <= 1'b0;
              exp_pins.data_out <= cur_q[bit_q]; // RL8
              st_q <= L_HIGH;
            end
          end
          L_HIGH: begin
            if (tick) begin
              exp_pins.expansion_shift_clock <= 1'b1; // RL11
              bit_q <= bit_q + 5'h01;
              if (bit_q != LCDPX_LAST_BIT) st_q <= L_LOW;
              else if (widx_q == LCDPX_LAST_WORD) st_q <= L_LATCH;
              else st_q <= L_WAIT;
            end
          end
          L_LATCH: begin
            // Frame end: latch pulse and polarity flip in step with the frame
            if (tick) begin
              exp_pins.expansion_shift_clock <= 1'b0;
              exp_pins.expansion_latch_clock <= 1'b1; // RL11
              exp_pins.polarity <= ~exp_pins.polarity; // RL11
              st_q <= L_WAIT;
            end
          end
          // Unused state codes fall back to idle rather than lock up
          default: st_q <= L_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: src/lcdpx_top.sv
// Power-down control and segment expansion for the on-chip LCD controller.
// Assumes one AHB-Lite master, pwr_mode from the power controller on sys_clk,
// and lcd_clk as the subclock that keeps running outside standby.
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: In watch, subactive, subsleep the display runs only on subclock frame sources.
// RL2: Software rewrites the frame clock select on medium-speed entry to keep frame rate.
// RL3: Display runs in active and sleep when active bit set; stopped in reset or cleared.
// RL4: Standby stops display and forces LCD drive supply off regardless of switch bit.
// RL5: Standby gates off subclock supply to the LCD logic though oscillator runs.
// RL6: Module standby stops the LCD clock and the display regardless of active bit.
// RL7: Software sets expansion select and programs segment range select to 0000/0001.
// RL8: Expansion data leaves from the first segment position; lower pins become ports.
// RL9: Clearing active halts expansion with clocks and polarity low, data held.
// RL10: Standby puts all expansion pins in high impedance.
// RL11: Expansion clocks and polarity follow the selected frame clock.
module lcdpx_top
  import lcdpx_pkg::*;
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // LCD subclock
  input wire logic lcd_clk,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power controller
  input wire lcdpx_pmode_t pwr_mode,
  // Power and clock controls
  output logic display_run,
  output logic lcd_supply_on,
  output logic subclk_supply_en,
  output logic lcd_block_clk_en,
  output logic seg_port_mode,
  // Expansion pins
  output lcdpx_exp_t exp_pins,
  output logic exp_oe
);

  // ==========================================================================
  // Bus decode
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  wire acc = hsel && hready && htrans[1] && (hsize == 3'h2);
  wire rd_acc = acc && !hwrite;
  wire wr_acc = acc && hwrite;
  wire wr_ctrl = wr_pend_q && (wr_addr_q == LCDPX_CTRL_OFS);
  wire wr_data = wr_pend_q && (wr_addr_q[7:4] == LCDPX_DATA_OFS[7:4]) &&
                 (wr_addr_q[1:0] == 2'h0);
  wire [1:0] wr_widx = wr_addr_q[3:2];
  wire [1:0] rd_widx = haddr[3:2];
  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Address phase captured for the write data phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_acc;
      if (wr_acc) wr_addr_q <= haddr;
    end
  end

  // ==========================================================================
  // Control register
  lcdpx_ctrl_t ctrl_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= LCDPX_CTRL_RST;
    else if (wr_ctrl) ctrl_q <= hwdata[11:0];
  end

  // ==========================================================================
  // Segment data words, read by the link through a handshake
  logic [31:0] seg_ram [LCDPX_NWORDS];
  genvar gi;
  generate
    for (gi = 0; gi < LCDPX_NWORDS; gi++) begin : g_ram
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) seg_ram[gi] <= 32'h0;
        else if (wr_data && wr_widx == 2'(gi)) seg_ram[gi] <= hwdata;
      end
    end
  endgenerate

  // ==========================================================================
  // Mode decode
  wire sub_src = !ctrl_q.frame_clock_select[LCDPX_FCS_SYS_BIT] &&
                 (ctrl_q.frame_clock_select[1:0] != 2'h3);
  wire mode_fast = (pwr_mode == LCDPX_PM_ACTIVE) || (pwr_mode == LCDPX_PM_SLEEP);
  wire mode_sub = (pwr_mode == LCDPX_PM_WATCH) || (pwr_mode == LCDPX_PM_SUBACTIVE) ||
                  (pwr_mode == LCDPX_PM_SUBSLEEP);
  wire mode_stby = (pwr_mode == LCDPX_PM_STANDBY);
  wire mode_mstby = (pwr_mode == LCDPX_PM_MODSTBY);
  // Display runs in fast modes, or sub modes only on a subclock source
  wire run_d = ctrl_q.display_active && // RL3
               (mode_fast || (mode_sub && sub_src)); // RL1 RL6
  wire supply_d = ctrl_q.lcd_supply_switch && !mode_stby; // RL4
  wire subclk_d = !mode_stby && !mode_mstby; // RL5
  wire clk_en_d = !mode_mstby; // RL6
  wire oe_d = !mode_stby && ctrl_q.segment_expansion_select; // RL10

  // Registered control outputs; reset holds the display stopped
  logic run_q;
  logic supply_q;
  logic subclk_q;
  logic clk_en_q;
  logic oe_q;
  logic port_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0; // RL3
      supply_q <= 1'b0;
      subclk_q <= 1'b1;
      clk_en_q <= 1'b1;
      oe_q <= 1'b0;
      port_q <= 1'b0;
    end else begin
      run_q <= run_d;
      supply_q <= supply_d;
      subclk_q <= subclk_d;
      clk_en_q <= clk_en_d;
      oe_q <= oe_d;
      port_q <= ctrl_q.segment_expansion_select; // RL8
    end
  end
  assign display_run = run_q;
  assign lcd_supply_on = supply_q;
  assign subclk_supply_en = subclk_q;
  assign lcd_block_clk_en = clk_en_q;
  assign seg_port_mode = port_q;
  assign exp_oe = oe_q;

  // ==========================================================================
  // System-clock frame source: a divided level the link edge-detects
  logic [LCDPX_SYSDIV_W-1:0] sdiv_q;
  logic sys_tick_q;
  wire [3:0] tap = {1'b0, ctrl_q.frame_clock_select[2:0]} + 4'h1;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdiv_q <= '0;
      sys_tick_q <= 1'b0;
    end else begin
      sdiv_q <= sdiv_q + 9'h001;
      sys_tick_q <= sdiv_q[tap]; // RL11
    end
  end

  // ==========================================================================
  // Fetch server: answers each link request with one stable word
  logic req_s1_q;
  logic req_s2_q;
  logic req_prev_q;
  logic ack_tgl_q;
  logic [31:0] word_q;
  logic req_tgl;
  logic [1:0] req_idx;
  // req_idx is held by the link while its request is pending
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_prev_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      word_q <= 32'h0;
    end else begin
      req_s1_q <= req_tgl;
      req_s2_q <= req_s1_q;
      req_prev_q <= req_s2_q;
      if (req_s2_q ^ req_prev_q) begin
        word_q <= seg_ram[req_idx]; // RL8
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  // ==========================================================================
  // Read data mux, registered into the data phase
  wire [31:0] stat_w = {28'h0, oe_q, subclk_q, supply_q, run_q};
  wire rd_ctrl = (haddr == LCDPX_CTRL_OFS);
  wire rd_stat = (haddr == LCDPX_STAT_OFS);
  wire rd_data = (haddr[7:4] == LCDPX_DATA_OFS[7:4]) && (haddr[1:0] == 2'h0);
  wire [31:0] rd_mux = rd_ctrl ? {20'h0, ctrl_q} :
                       rd_stat ? stat_w :
                       rd_data ? seg_ram[rd_widx] : 32'h0;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rdata_q <= 32'h0;
    else if (rd_acc) rdata_q <= rd_mux;
  end

  // ==========================================================================
  // Link domain serialiser
  wire link_run = run_q && subclk_q && clk_en_q && ctrl_q.segment_expansion_select;
  lcdpx_link u_link (
    .lcd_clk(lcd_clk),
    .rst_b(rst_b),
    .run_lvl(link_run), // RL9
    .use_sys(ctrl_q.frame_clock_select[LCDPX_FCS_SYS_BIT]),
    .sub_div(ctrl_q.frame_clock_select[1:0]),
    .sys_tick_lvl(sys_tick_q),
    .req_tgl(req_tgl),
    .req_idx(req_idx),
    .ack_tgl(ack_tgl_q),
    .word(word_q),
    .exp_pins(exp_pins)
  );

endmodule
`default_nettype wire

// File: bench/lcdpx_top_properties.sv
// Checker for lcdpx_top: power-down outputs and expansion pin framing.
// Assumes it is bound to lcdpx_top and sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
module lcdpx_props
  import lcdpx_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic lcd_clk,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Mode and outputs
  input wire lcdpx_pmode_t pwr_mode,
  input wire logic display_run,
  input wire logic lcd_supply_on,
  input wire logic subclk_supply_en,
  input wire logic lcd_block_clk_en,
  input wire logic seg_port_mode,
  input wire lcdpx_exp_t exp_pins,
  input wire logic exp_oe
);
  // =====
  // Control mirror
  logic wr_q;
  logic [11:0] ctl_q;
  logic [1:0] calm_q;
  lcdpx_pmode_t mode_q;
  // Control write decode and expected run state
  wire logic wr_ctl = hsel && hready && htrans[1] && hwrite && hsize == 3'h2
    && haddr == LCDPX_CTRL_OFS;
  wire logic sub_md = pwr_mode inside {LCDPX_PM_WATCH, LCDPX_PM_SUBACTIVE, LCDPX_PM_SUBSLEEP};
  wire logic run_exp = ctl_q[0] && (pwr_mode == LCDPX_PM_ACTIVE
    || pwr_mode == LCDPX_PM_SLEEP || (sub_md && !ctl_q[7] && ctl_q[5:4] != 2'h3));
  wire logic calm = calm_q == 2'h3 && mode_q == pwr_mode; // New mode lands one edge later
  wire logic stby = pwr_mode == LCDPX_PM_STANDBY;
  wire logic mstby = pwr_mode == LCDPX_PM_MODSTBY;
  wire logic quiet = !display_run && subclk_supply_en && lcd_block_clk_en;
  // Calm waits out the output register stage after any mode or control change
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'h0;
      ctl_q <= LCDPX_CTRL_RST;
      calm_q <= 2'h0;
      mode_q <= LCDPX_PM_ACTIVE;
    end else begin
      wr_q <= wr_ctl;
      mode_q <= pwr_mode;
      if (wr_q) ctl_q <= hwdata[11:0];
      if (wr_q || mode_q != pwr_mode) calm_q <= 2'h0;
      else if (!calm) calm_q <= calm_q + 2'h1;
    end
  end
  // =====
  // System-side outputs
  a_run_by_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
    calm |-> display_run == run_exp) else $error("display run wrong");
  a_supply_standby: assert property (@(posedge sys_clk) disable iff (!rst_b)
    calm && stby |-> !lcd_supply_on) else $error("supply on in standby");
  a_subclk_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    calm && !mstby |-> subclk_supply_en == !stby) else $error("subclock gate wrong");
  a_block_clock: assert property (@(posedge sys_clk) disable iff (!rst_b)
    calm && !stby |-> lcd_block_clk_en == !mstby) else $error("block clock wrong");
  a_pins_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
    calm && stby |-> !exp_oe) else $error("pins driven in standby");
  a_port_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
    calm |-> seg_port_mode == ctl_q[2]) else $error("port mode wrong");
  // Link pins; bits 2:0 are latch, shift and polarity
  a_halt_low: assert property (@(posedge lcd_clk) disable iff (!rst_b)
    quiet [*5] |-> exp_pins[2:0] == 3'h0) else $error("halt not low");
  a_data_held: assert property (@(posedge lcd_clk) disable iff (!rst_b)
    quiet [*5] |=> $stable(exp_pins.data_out)) else $error("data moved in halt");
  a_latch_alone: assert property (@(posedge lcd_clk) disable iff (!rst_b)
    exp_pins.expansion_latch_clock |-> !exp_pins.expansion_shift_clock)
    else $error("latch with shift high");
  a_pol_on_latch: assert property (@(posedge lcd_clk) disable iff (!rst_b)
    $changed(exp_pins.polarity) |-> exp_pins.expansion_latch_clock || !exp_pins.polarity)
    else $error("polarity moved off latch");
endmodule
bind lcdpx_top lcdpx_props u_props (.sys_clk, .rst_b, .lcd_clk, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .pwr_mode, .display_run, .lcd_supply_on,
  .subclk_supply_en, .lcd_block_clk_en, .seg_port_mode, .exp_pins, .exp_oe);
`default_nettype wire

// File: bench/lcdpx_seg_model.sv
// Model of the external segment driver: shifts, latches, checks polarity.
// Assumes it sees the expansion wires after floating is resolved.
`timescale 1ns/1ps
`default_nettype none
module lcdpx_seg_model
  import lcdpx_pkg::*;
(
  // Subclock and reset
  input wire logic lcd_clk,
  input wire logic rst_b,
  // Board wires and captured frame
  input wire lcdpx_exp_t ew,
  output logic [127:0] frame_q,
  output logic [7:0] frames_q,
  output logic [7:0] pol_err_q
);
  logic [127:0] sr_q;
  logic sh_q, la_q, pol_q;
  // A floating clock wire never counts as a rising edge
  wire logic sh_up = ew.expansion_shift_clock === 1'h1 && !sh_q;
  wire logic la_up = ew.expansion_latch_clock === 1'h1 && !la_q;
  // First segment enters first; each latch after the first must swap the polarity
  always_ff @(posedge lcd_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sr_q, frame_q, frames_q, pol_err_q, sh_q, la_q, pol_q} <= '0;
    end else begin
      sh_q <= ew.expansion_shift_clock === 1'h1;
      la_q <= ew.expansion_latch_clock === 1'h1;
      if (sh_up) sr_q <= {ew.data_out, sr_q[127:1]};
      if (la_up) begin
        frame_q <= sr_q;
        frames_q <= frames_q + 8'h1;
        pol_q <= ew.polarity;
        if (frames_q != 8'h0 && ew.polarity === pol_q) pol_err_q <= pol_err_q + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/lcdpx_bench.sv
// Bench for lcdpx_top: bus, mode sweep, expansion frames, halt, standby.
// Assumes one bus master and the driver model on the resolved wires.
`timescale 1ns/1ps
`default_nettype none
module lcdpx_bench
  import lcdpx_pkg::*;
;
  // =====
  // Stimulus and observed signals
  logic sys_clk = 1'h0, lcd_clk = 1'h0, rst_b = 1'h0;
  logic hsel = 1'h0, hwrite = 1'h0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, run, sup, sub, blk, spm, oe;
  lcdpx_pmode_t pwr_mode = LCDPX_PM_ACTIVE;
  lcdpx_exp_t pins;
  wire lcdpx_exp_t ew = oe ? pins : 4'hz;
  logic [127:0] frame;
  logic [7:0] frames, pol_err;
  int err_count = 0, num_checks = 0, cyc = 0;
  localparam logic [127:0] PAT = 128'h0123_4567_89ab_cdef_f0e1_d2c3_b4a5_9687;
  // Unrelated clocks: their rising edges never coincide
  always #25 sys_clk = ~sys_clk;
  always #7.5 lcd_clk = ~lcd_clk;
  // Single slave, so its hreadyout is the bus hready
  lcdpx_top uut (.sys_clk, .rst_b, .lcd_clk, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pwr_mode,
    .display_run(run), .lcd_supply_on(sup), .subclk_supply_en(sub),
    .lcd_block_clk_en(blk), .seg_port_mode(spm), .exp_pins(pins), .exp_oe(oe));
  lcdpx_seg_model drv (.lcd_clk, .rst_b, .ew, .frame_q(frame), .frames_q(frames),
    .pol_err_q(pol_err));
  // =====
  // Shared tasks
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One word transfer; waits on hready in both phases, read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // =====
  // Reset values, data words and an unmapped place
  task automatic t_regs;
    bus(1'h0, LCDPX_CTRL_OFS, 32'h0);
    chk(rd, 32'h0, "control reset");
    bus(1'h0, LCDPX_STAT_OFS, 32'h0);
    chk(rd, 32'(1) << LCDPX_ST_SUBCLK, "status reset");
    chk(hresp, 1'h0, "bus response");
    chk(run, 1'h0, "run after reset");
    for (int i = 0; i < 4; i++) bus(1'h1, LCDPX_DATA_OFS + 8'(4 * i), PAT[32 * i +: 32]);
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, LCDPX_DATA_OFS + 8'(4 * i), 32'h0);
      chk(rd, PAT[32 * i +: 32], "data word");
    end
    bus(1'h1, 8'h40, 32'hffff_ffff);
    bus(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("register test done");
  endtask
  // Every mode under each frame source, then with the display bit clear
  task automatic t_modes;
    logic [11:0] cl [6] = '{12'h001, 12'h011, 12'h021, 12'h031, 12'h091, 12'h000};
    logic ok;
    for (int f = 0; f < 6; f++) begin
      bus(1'h1, LCDPX_CTRL_OFS, {20'h0, cl[f]});
      for (int m = 0; m < 7; m++) begin
        pwr_mode <= lcdpx_pmode_t'(m);
        repeat (4) @(posedge sys_clk);
        ok = cl[f][0] && (m < 2 || (m < 5 && !cl[f][7] && cl[f][5:4] != 2'h3));
        chk(run, ok, "display run");
        if (m != 5) chk(blk, m != 6, "block clock");
      end
    end
    pwr_mode <= LCDPX_PM_ACTIVE;
    $display("mode sweep done");
  endtask
  // Frames at both legal segment ranges, dividers one, two and four, then system source
  // After each rewrite of the frame source in mid-run, the frame latched third must carry the whole pattern
  task automatic t_expand;
    logic [31:0] cv [4] = '{32'h0007, 32'h0117, 32'h0127, 32'h0087};
    logic [7:0] f0;
    for (int s = 0; s < 4; s++) begin
      bus(1'h1, LCDPX_CTRL_OFS, cv[s]);
      f0 = frames;
      for (int i = 0; i < 4000 && frames < f0 + 8'h3; i++) @(posedge sys_clk);
      chk(frames - f0 >= 8'h3, 1'h1, "frame count");
      chk(spm, 1'h1, "port mode");
      chk(frame, PAT, "frame bits");
      chk(pol_err, 8'h0, "polarity swap");
    end
    $display("expansion test done");
  endtask
  // Clearing the display bit in mid-frame
  task automatic t_halt;
    logic d;
    bus(1'h1, LCDPX_CTRL_OFS, 32'h0006);
    repeat (4) @(posedge sys_clk);
    chk(pins[2:0], 3'h0, "halt levels");
    d = pins.data_out;
    repeat (20) @(posedge sys_clk);
    chk(pins.data_out, d, "data held");
    $display("halt test done");
  endtask
  // Standby with the supply switch set, then back to active
  task automatic t_standby;
    bus(1'h1, LCDPX_CTRL_OFS, 32'h0007);
    pwr_mode <= LCDPX_PM_STANDBY;
    repeat (4) @(posedge sys_clk);
    chk({run, sup, sub, oe}, 4'h0, "standby outputs");
    chk(ew, 4'hz, "pins float");
    bus(1'h0, LCDPX_STAT_OFS, 32'h0);
    chk(rd, 32'h0, "standby status");
    pwr_mode <= LCDPX_PM_ACTIVE;
    repeat (4) @(posedge sys_clk);
    chk({run, sup, sub, oe}, 4'hf, "active outputs");
    $display("standby test done");
  endtask
  // =====
  // Verdict and the only exit
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard; the whole run needs a few thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  // Reset for eight cycles, then the scenarios
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_regs;
    t_modes;
    t_expand;
    t_halt;
    t_standby;
    end_sim;
  end
endmodule
`default_nettype wire
